//--- logic/audio_port_frame_sync_pins.sv
// Purpose: Pin function logic for the receive and transmit frame-sync pins
// Assumes: Control bits come from logic on sys_clk_i; pins and bit clock are asynchronous
// Notes:   Flag updates follow the frame-sync or slot strobe edge seen on sys_clk_i
// What this block does
// - Async mode: receive pin is receiver frame sync
// - Sync mode, buffer select clear: flag one
// - Sync, buffer select and direction: buffer enable out
// - Flag direction comes from receive direction bit
// - Output flag drives pin from output flag one
// - Output flag updates on frame or slot
// - Input flag captured on frame or slot
// - Sync mode: transmit pin serves both directions
// - Async mode: transmit pin serves transmitters only
// - Transmit pin direction from transmit direction bit
// - Port lines individually input, output or off
// - Reset leaves both pins disconnected port lines
`timescale 1ns/10ps
module audio_port_frame_sync_pins (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Mode and direction controls
  input  wire logic       port_enable_i,
  input  wire logic       sync_mode_select_i,
  input  wire logic       tx_buffer_enable_select_i,
  input  wire logic       rx_frame_sync_direction_i,
  input  wire logic       tx_frame_sync_direction_i,
  input  wire logic       network_mode_i,
  input  wire logic       output_flag_one_i,
  // General-purpose controls for port line one and port line four
  input  wire logic [1:0] port_line_one_dir_i,
  input  wire logic [1:0] port_line_four_dir_i,
  input  wire logic       port_line_one_out_i,
  input  wire logic       port_line_four_out_i,
  // Internal frame syncs, slot strobe and transmit buffer enable
  input  wire logic       rx_frame_sync_line_i,
  input  wire logic       tx_frame_sync_line_i,
  input  wire logic       slot_strobe_i,
  input  wire logic       tx_buffer_active_i,
  // Receive frame-sync pin
  input  wire logic       receive_frame_sync_pin_i,
  output logic            receive_frame_sync_pin_o,
  output logic            receive_frame_sync_pin_oe_o,
  // Transmit frame-sync pin
  input  wire logic       transmit_frame_sync_pin_i,
  output logic            transmit_frame_sync_pin_o,
  output logic            transmit_frame_sync_pin_oe_o,
  // Status towards software and the serial logic
  output logic            input_flag_one_o,
  output logic            rx_frame_sync_line_o,
  output logic            tx_frame_sync_line_o,
  output logic            port_line_one_in_o,
  output logic            port_line_four_in_o
);

  typedef struct packed {
    fs_pins_pkg::pin_func_t rx_func;
    fs_pins_pkg::pin_func_t tx_func;
    logic                   flag_out;
    logic                   flag_in;
    logic                   strobe_prev;
    logic                   rx_fs;
    logic                   tx_fs;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;
  logic       rx_level;
  logic       tx_level;
  logic       strobe;
  logic       strobe_edge;
  logic       rx_drive;
  logic       tx_drive;

  // Maps a general-purpose direction code onto a pin function
  function automatic fs_pins_pkg::pin_func_t gp_func(input logic [1:0] dir);
    case (dir)
      fs_pins_pkg::GP_DIR_IN:  gp_func = fs_pins_pkg::PIN_GP_IN;
      fs_pins_pkg::GP_DIR_OUT: gp_func = fs_pins_pkg::PIN_GP_OUT;
      default:                 gp_func = fs_pins_pkg::PIN_GP_OFF;
    endcase
  endfunction

  // Flag timing follows the transmit frame sync or the slot strobe
  assign strobe      = network_mode_i ? slot_strobe_i : state_reg.tx_fs;
  assign strobe_edge = strobe & ~state_reg.strobe_prev;

  // Function selection, flag update and frame-sync routing
  always_comb begin
    state_next = state_reg;
    if (!port_enable_i) begin
      state_next.rx_func = gp_func(port_line_one_dir_i);
      state_next.tx_func = gp_func(port_line_four_dir_i);
    end else begin
      if (!sync_mode_select_i) begin
        state_next.rx_func = rx_frame_sync_direction_i ? fs_pins_pkg::PIN_SYNC_OUT
                                                        : fs_pins_pkg::PIN_SYNC_IN;
      end else if (!tx_buffer_enable_select_i) begin
        state_next.rx_func = rx_frame_sync_direction_i ? fs_pins_pkg::PIN_FLAG_OUT
                                                        : fs_pins_pkg::PIN_FLAG_IN;
      end else if (rx_frame_sync_direction_i) begin
        state_next.rx_func = fs_pins_pkg::PIN_BUF_EN;
      end else begin
        state_next.rx_func = fs_pins_pkg::PIN_GP_OFF; // Input with buffer select is undefined
      end
      state_next.tx_func = tx_frame_sync_direction_i ? fs_pins_pkg::PIN_SYNC_OUT
                                                      : fs_pins_pkg::PIN_SYNC_IN;
    end
    state_next.strobe_prev = strobe;
    if (strobe_edge) begin
      state_next.flag_out = output_flag_one_i;
      if (state_reg.rx_func == fs_pins_pkg::PIN_FLAG_IN) begin
        state_next.flag_in = rx_level;
      end
    end
    // Transmit frame sync: pin when input, internal line when output
    state_next.tx_fs = (state_reg.tx_func == fs_pins_pkg::PIN_SYNC_IN) ? tx_level
                                                                       : tx_frame_sync_line_i;
    if (sync_mode_select_i) begin
      state_next.rx_fs = state_next.tx_fs;
    end else begin
      state_next.rx_fs = (state_reg.rx_func == fs_pins_pkg::PIN_SYNC_IN) ? rx_level
                                                                         : rx_frame_sync_line_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= '{rx_func: fs_pins_pkg::PIN_GP_OFF, tx_func: fs_pins_pkg::PIN_GP_OFF,
                     flag_out: fs_pins_pkg::FLAG_RESET, flag_in: fs_pins_pkg::FLAG_RESET,
                     strobe_prev: 1'h0, rx_fs: 1'h0, tx_fs: 1'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Drive values per function
  always_comb begin
    case (state_reg.rx_func)
      fs_pins_pkg::PIN_GP_OUT:   rx_drive = port_line_one_out_i;
      fs_pins_pkg::PIN_SYNC_OUT: rx_drive = rx_frame_sync_line_i;
      fs_pins_pkg::PIN_FLAG_OUT: rx_drive = state_reg.flag_out;
      fs_pins_pkg::PIN_BUF_EN:   rx_drive = tx_buffer_active_i;
      default:                   rx_drive = 1'h0;
    endcase
    case (state_reg.tx_func)
      fs_pins_pkg::PIN_GP_OUT:   tx_drive = port_line_four_out_i;
      fs_pins_pkg::PIN_SYNC_OUT: tx_drive = tx_frame_sync_line_i;
      default:                   tx_drive = 1'h0;
    endcase
  end

  // Pin cells; the partner must hold sync edges one bit clock to be seen
  fs_pin_cell u_rx_cell (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .func_i      (state_reg.rx_func),
    .drive_val_i (rx_drive),
    .pin_i       (receive_frame_sync_pin_i),
    .pin_o       (receive_frame_sync_pin_o),
    .pin_oe_o    (receive_frame_sync_pin_oe_o),
    .level_o     (rx_level)
  );

  fs_pin_cell u_tx_cell (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .func_i      (state_reg.tx_func),
    .drive_val_i (tx_drive),
    .pin_i       (transmit_frame_sync_pin_i),
    .pin_o       (transmit_frame_sync_pin_o),
    .pin_oe_o    (transmit_frame_sync_pin_oe_o),
    .level_o     (tx_level)
  );

  assign input_flag_one_o     = state_reg.flag_in;
  assign rx_frame_sync_line_o = state_reg.rx_fs;
  assign tx_frame_sync_line_o = state_reg.tx_fs;
  assign port_line_one_in_o   = (state_reg.rx_func == fs_pins_pkg::PIN_GP_IN) & rx_level;
  assign port_line_four_in_o  = (state_reg.tx_func == fs_pins_pkg::PIN_GP_IN) & tx_level;

  // Checks on pin function and drive
  // A mode must stand two edges before the registered function code follows it
  sequence s_async_held;
    (port_enable_i && !sync_mode_select_i)[*2];
  endsequence

  sequence s_flag_sel_held;
    (port_enable_i && sync_mode_select_i && !tx_buffer_enable_select_i)[*2];
  endsequence

  sequence s_buf_en_held;
    (port_enable_i && sync_mode_select_i && tx_buffer_enable_select_i
     && rx_frame_sync_direction_i)[*2];
  endsequence

  a_reset_disconnects: assert property (@(posedge sys_clk_i) rst_i |=> ##1
    (!receive_frame_sync_pin_oe_o && !transmit_frame_sync_pin_oe_o))
    else $error("Pins driven after reset");
  a_async_rx_sync: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_async_held |->
    (state_reg.rx_func inside {fs_pins_pkg::PIN_SYNC_IN, fs_pins_pkg::PIN_SYNC_OUT}))
    else $error("Receive pin not frame sync in async mode");
  a_sync_flag_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_flag_sel_held |->
    (state_reg.rx_func inside {fs_pins_pkg::PIN_FLAG_IN, fs_pins_pkg::PIN_FLAG_OUT}))
    else $error("Receive pin not flag in sync mode");
  a_buf_en_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_buf_en_held |=> receive_frame_sync_pin_oe_o)
    else $error("Buffer enable not driven");
  a_flag_direction: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_reg.rx_func == fs_pins_pkg::PIN_FLAG_IN) |=> !receive_frame_sync_pin_oe_o)
    else $error("Input flag pin driven");
  a_flag_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    strobe_edge |=> (state_reg.flag_out == $past(output_flag_one_i)))
    else $error("Output flag not latched on strobe");
  a_flag_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !strobe_edge |=> $stable(state_reg.flag_out))
    else $error("Output flag changed off strobe");
  a_flag_capture: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (strobe_edge && state_reg.rx_func == fs_pins_pkg::PIN_FLAG_IN) |=>
    (input_flag_one_o == $past(rx_level)))
    else $error("Input flag not captured");
  a_sync_shared: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sync_mode_select_i |=> (rx_frame_sync_line_o == tx_frame_sync_line_o))
    else $error("Sync mode frame syncs differ");
  a_tx_direction: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (port_enable_i && !tx_frame_sync_direction_i)[*2] |=> !transmit_frame_sync_pin_oe_o)
    else $error("Transmit pin driven as input");
  a_gp_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!port_enable_i && port_line_four_dir_i == fs_pins_pkg::GP_DIR_OFF)[*2] |=>
    (!transmit_frame_sync_pin_oe_o && !port_line_four_in_o))
    else $error("Disconnected line active");
endmodule

//--- logic/fs_pins_pkg.sv
// Purpose: Shared constants and types for the frame-sync pin function block
// Assumes: 100 MHz system clock, all pin and bit-clock inputs asynchronous
// Notes:   Pin function codes are used by the top and the pin cell
package fs_pins_pkg;

  // Function selected for each frame-sync pin
  typedef enum logic [2:0] {
    PIN_GP_OFF    = 3'b000,
    PIN_GP_IN     = 3'b001,
    PIN_GP_OUT    = 3'b010,
    PIN_SYNC_IN   = 3'b011,
    PIN_SYNC_OUT  = 3'b100,
    PIN_FLAG_IN   = 3'b101,
    PIN_FLAG_OUT  = 3'b110,
    PIN_BUF_EN    = 3'b111
  } pin_func_t;

  // General-purpose line direction codes
  localparam logic [1:0] GP_DIR_OFF = 2'h0;
  localparam logic [1:0] GP_DIR_IN  = 2'h1;
  localparam logic [1:0] GP_DIR_OUT = 2'h2;

  // Synchroniser depth and reset values
  localparam int         SYNC_STAGES    = 2;
  localparam logic       FLAG_RESET     = 1'h0;
  localparam logic [1:0] SYNC_RESET     = 2'h0;

  // System clock and bit-clock timing
  localparam int SYS_CLK_MHZ      = 100;
  localparam int MIN_BCLK_NS      = 80;
  localparam int MIN_BCLK_CYCLES  = (MIN_BCLK_NS * SYS_CLK_MHZ + 999) / 1000;

endpackage

//--- logic/fs_pin_cell.sv
// Purpose: One frame-sync pin: input synchroniser and output drive from a function code
// Assumes: Pin input asynchronous to sys_clk_i
// Notes:   Disconnected lines neither drive nor pass the sampled level on
`timescale 1ns/10ps
module fs_pin_cell (
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // Function and drive value
  input  wire fs_pins_pkg::pin_func_t func_i,
  input  wire logic                  drive_val_i,
  // Pin
  input  wire logic                  pin_i,
  output logic                       pin_o,
  output logic                       pin_oe_o,
  // Synchronised level, zero when the pin is not sampled
  output logic                       level_o
);

  typedef struct packed {
    logic [1:0] sync;
    logic       out;
    logic       oe;
  } cell_state_t;

  cell_state_t state_reg;
  cell_state_t state_next;
  logic        sampling;

  // Pin is sampled only in the input functions
  assign sampling = (func_i == fs_pins_pkg::PIN_GP_IN) || (func_i == fs_pins_pkg::PIN_SYNC_IN)
                    || (func_i == fs_pins_pkg::PIN_FLAG_IN);

  // Next state: two-stage synchroniser and registered drive
  always_comb begin
    state_next      = state_reg;
    state_next.sync = {state_reg.sync[0], pin_i};
    state_next.oe   = (func_i == fs_pins_pkg::PIN_GP_OUT) || (func_i == fs_pins_pkg::PIN_SYNC_OUT)
                      || (func_i == fs_pins_pkg::PIN_FLAG_OUT) || (func_i == fs_pins_pkg::PIN_BUF_EN);
    state_next.out  = state_next.oe & drive_val_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= '{sync: fs_pins_pkg::SYNC_RESET, out: 1'h0, oe: 1'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_o    = state_reg.out;
  assign pin_oe_o = state_reg.oe;
  assign level_o  = sampling & state_reg.sync[1]; // Only the second stage is read
endmodule

//--- verification/codec_model.sv
// Purpose: Behavioural external codec that drives the frame-sync pins as inputs
// Assumes: The bench resolves each wire from both parties' drive flags
// Notes:   Its bit clock stands still while it drives no pin
`timescale 1ns/10ps
module codec_model (
  // Drive requests from the bench
  input  wire logic rx_en_i,
  input  wire logic rx_lvl_i,
  input  wire logic tx_en_i,
  input  wire logic tx_lvl_i,
  // Levels and drive flags at the pins
  output logic      rx_pin_o,
  output logic      rx_drv_o,
  output logic      tx_pin_o,
  output logic      tx_drv_o
);
  logic bclk;
  logic rx_lvl_q = 1'h0;
  logic tx_lvl_q = 1'h0;

  // Bit clock of 80 ns, only while the codec drives something
  initial begin
    bclk = 1'h0;
    forever #40 bclk = (rx_en_i | tx_en_i) ? ~bclk : 1'h0;
  end

  // Levels change on a bit clock edge only, so each holds a full period
  always @(posedge bclk) begin
    rx_lvl_q <= rx_lvl_i;
    tx_lvl_q <= tx_lvl_i;
  end

  // Pin levels and drive flags
  assign rx_pin_o = rx_lvl_q;
  assign tx_pin_o = tx_lvl_q;
  assign rx_drv_o = rx_en_i;
  assign tx_drv_o = tx_en_i;
endmodule

//--- verification/audio_port_frame_sync_pins_bench.sv
// Purpose: Self-checking bench for the frame-sync pin function block
// Assumes: Controls change at the falling edge; codec model drives input pins
// Notes:   Undriven wires toggle every cycle so stale levels cannot pass
`timescale 1ns/10ps
module audio_port_frame_sync_pins_bench;
  logic sys_clk = 1'h0, rst = 1'h1, idle_tgl = 1'h0;
  logic port_en = 1'h0, sync_sel = 1'h0, buf_sel = 1'h0, rx_dir = 1'h0, tx_dir = 1'h0;
  logic net_mode = 1'h0, flag_out = 1'h0, gp1_val = 1'h0, gp4_val = 1'h0;
  logic [1:0] gp1_dir = 2'h0, gp4_dir = 2'h0;
  logic rx_fs = 1'h0, tx_fs = 1'h0, slot = 1'h0, buf_act = 1'h0;
  logic rx_en = 1'h0, rx_lvl = 1'h0, tx_en = 1'h0, tx_lvl = 1'h0;
  logic rx_far, rx_drv, tx_far, tx_drv, rx_wire, tx_wire;
  logic rx_o, rx_oe, tx_o, tx_oe, iflag, rx_line, tx_line, gp1_in, gp4_in;
  int   mismatches = 0;
  int   checked = 0;

  // Clock and a toggling level for wires nobody drives
  initial forever #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) idle_tgl <= ~idle_tgl;

  // Wire levels from both parties' enables
  assign rx_wire = rx_oe ? rx_o : (rx_drv ? rx_far : idle_tgl);
  assign tx_wire = tx_oe ? tx_o : (tx_drv ? tx_far : idle_tgl);

  audio_port_frame_sync_pins u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .port_enable_i(port_en),
    .sync_mode_select_i(sync_sel), .tx_buffer_enable_select_i(buf_sel),
    .rx_frame_sync_direction_i(rx_dir), .tx_frame_sync_direction_i(tx_dir),
    .network_mode_i(net_mode), .output_flag_one_i(flag_out), .port_line_one_dir_i(gp1_dir),
    .port_line_four_dir_i(gp4_dir), .port_line_one_out_i(gp1_val), .port_line_four_out_i(gp4_val),
    .rx_frame_sync_line_i(rx_fs), .tx_frame_sync_line_i(tx_fs), .slot_strobe_i(slot),
    .tx_buffer_active_i(buf_act), .receive_frame_sync_pin_i(rx_wire),
    .receive_frame_sync_pin_o(rx_o), .receive_frame_sync_pin_oe_o(rx_oe),
    .transmit_frame_sync_pin_i(tx_wire), .transmit_frame_sync_pin_o(tx_o),
    .transmit_frame_sync_pin_oe_o(tx_oe), .input_flag_one_o(iflag),
    .rx_frame_sync_line_o(rx_line), .tx_frame_sync_line_o(tx_line),
    .port_line_one_in_o(gp1_in), .port_line_four_in_o(gp4_in));

  codec_model u_codec (.rx_en_i(rx_en), .rx_lvl_i(rx_lvl), .tx_en_i(tx_en), .tx_lvl_i(tx_lvl),
    .rx_pin_o(rx_far), .rx_drv_o(rx_drv), .tx_pin_o(tx_far), .tx_drv_o(tx_drv));

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic cmp(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Mode bits: enable, sync, buffer select, receive and transmit direction
  task automatic mode(input logic a, input logic b, input logic c, input logic d, input logic e);
    {port_en, sync_sel, buf_sel, rx_dir, tx_dir} = {a, b, c, d, e};
    cyc(8);
  endtask

  // Codec drive requests; long enough for its bit clock and the synchroniser
  task automatic far(input logic re, input logic rl, input logic te, input logic tl);
    {rx_en, rx_lvl, tx_en, tx_lvl} = {re, rl, te, tl};
    cyc(16);
  endtask

  // One strobe: transmit frame sync or slot
  task automatic pulse(input logic use_slot);
    if (use_slot) slot = 1'h1;
    else tx_fs = 1'h1;
    cyc(4);
    {slot, tx_fs} = 2'h0;
    cyc(6);
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end

  // Main sequence
  initial begin
    // Codec drives both pins high through a four-cycle reset
    {rx_en, rx_lvl, tx_en, tx_lvl} = 4'hf;
    cyc(4);
    cmp("rx oe in reset", 1'h0, rx_oe);
    cmp("tx oe in reset", 1'h0, tx_oe);
    rst = 1'h0;
    cyc(4);
    cmp("line four in", 1'h0, gp4_in);
    // General-purpose lines, one output and one input, then off
    {gp1_dir, gp1_val, gp4_dir} = {2'h2, 1'h1, 2'h1};
    cyc(6);
    cmp("rx oe gp out", 1'h1, rx_oe);
    cmp("rx o gp out", 1'h1, rx_o);
    cmp("tx oe gp in", 1'h0, tx_oe);
    cmp("line four in", 1'h1, gp4_in);
    {gp1_dir, gp4_dir} = {2'h3, 2'h0};
    cyc(6);
    cmp("rx oe gp off", 1'h0, rx_oe);
    cmp("line four off", 1'h0, gp4_in);
    cmp("line one off", 1'h0, gp1_in);
    gp1_dir = 2'h1;
    cyc(6);
    cmp("line one in", 1'h1, gp1_in);
    {gp4_dir, gp4_val} = {2'h2, 1'h1};
    cyc(6);
    cmp("tx oe gp out", 1'h1, tx_oe);
    cmp("tx o gp out", 1'h1, tx_o);
    // Asynchronous mode, both pins outputs then inputs
    {rx_fs, tx_fs} = 2'h2;
    mode(1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    cmp("rx oe async", 1'h1, rx_oe);
    cmp("rx o async", 1'h1, rx_o);
    cmp("tx o async", 1'h0, tx_o);
    {rx_fs, tx_fs} = 2'h1;
    cyc(6);
    cmp("rx o async", 1'h0, rx_o);
    cmp("tx o async", 1'h1, tx_o);
    tx_fs = 1'h0;
    mode(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    far(1'h1, 1'h1, 1'h1, 1'h0);
    cmp("tx oe input", 1'h0, tx_oe);
    cmp("rx line async", 1'h1, rx_line);
    cmp("tx line async", 1'h0, tx_line);
    far(1'h1, 1'h0, 1'h1, 1'h1);
    cmp("rx line own", 1'h0, rx_line);
    cmp("tx line async", 1'h1, tx_line);
    // Synchronous mode, transmit pin input serves both directions
    far(1'h1, 1'h0, 1'h1, 1'h0);
    mode(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    far(1'h1, 1'h0, 1'h1, 1'h1);
    cmp("tx line sync", 1'h1, tx_line);
    cmp("rx line sync", 1'h1, rx_line);
    // Output flag, updated only on its strobe
    far(1'h0, 1'h0, 1'h0, 1'h0);
    mode(1'h1, 1'h1, 1'h0, 1'h1, 1'h1);
    flag_out = 1'h1;
    cyc(6);
    cmp("flag oe", 1'h1, rx_oe);
    cmp("flag before", 1'h0, rx_o);
    pulse(1'h0);
    cmp("flag frame", 1'h1, rx_o);
    {net_mode, flag_out} = 2'h2;
    pulse(1'h0);
    cmp("flag net frame", 1'h1, rx_o);
    pulse(1'h1);
    cmp("flag net slot", 1'h0, rx_o);
    // Input flag, captured only on its strobe
    mode(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
    far(1'h1, 1'h1, 1'h0, 1'h0);
    cmp("flag in oe", 1'h0, rx_oe);
    cmp("flag in before", 1'h0, iflag);
    pulse(1'h1);
    cmp("flag in slot", 1'h1, iflag);
    net_mode = 1'h0;
    far(1'h1, 1'h0, 1'h0, 1'h0);
    pulse(1'h1);
    cmp("flag in no slot", 1'h1, iflag);
    pulse(1'h0);
    cmp("flag in frame", 1'h0, iflag);
    // Transmit buffer enable, refused with input direction
    far(1'h0, 1'h0, 1'h0, 1'h0);
    buf_act = 1'h1;
    mode(1'h1, 1'h1, 1'h1, 1'h1, 1'h1);
    cmp("buf oe", 1'h1, rx_oe);
    cmp("buf o", 1'h1, rx_o);
    buf_act = 1'h0;
    cyc(4);
    cmp("buf o", 1'h0, rx_o);
    mode(1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
    cmp("buf oe off", 1'h0, rx_oe);
    // Second reset with the transmit pin driving
    rst = 1'h1;
    cyc(3);
    cmp("tx oe reset", 1'h0, tx_oe);
    cmp("rx oe reset", 1'h0, rx_oe);
    rst = 1'h0;
    cyc(1);
    cmp("tx oe first edge", 1'h0, tx_oe);
    cyc(3);
    cmp("tx oe after reset", 1'h1, tx_oe);
    stop_test();
  end
endmodule
